/* bench/ssp_peer_model.sv */
// Client peer for the host link: returns one byte, captures one byte.
// Assumes idle-low SCK, data shown before the leading edge.
`timescale 1ns/1ps
module ssp_peer_model (
  input  wire logic       clk_in,   // Bench clock
  input  wire logic       sck_in,   // SCK wire
  input  wire logic       sdo_in,   // Data from port
  input  wire logic       sel_n_in, // Frame select
  input  wire logic [7:0] tx_in,    // Byte to return
  output logic            sdi_out,  // Data to port
  output logic      [7:0] rx_out    // Byte captured
);
  logic       sck_r, sel_r;
  logic [7:0] sh_r;
  // A released line toggles so a stale bit never passes for data.
  assign sdi_out = sel_n_in ? clk_in : sh_r[7];
  always @(posedge clk_in) begin
    sck_r <= sck_in;
    sel_r <= sel_n_in;
    if (sel_r && !sel_n_in) sh_r <= tx_in;
    else if (!sel_n_in && sck_in && !sck_r)
      rx_out <= {rx_out[6:0], sdo_in};
    else if (!sel_n_in && !sck_in && sck_r)
      sh_r <= {sh_r[6:0], 1'b0};
  end
endmodule

/* bench/ssp_port_monitor.sv */
// Checker for the serial port: APB timing, pin release, SCK counts.
// Assumes the bind below reaches every instance of the port.
`timescale 1ns/1ps
module ssp_port_monitor (
  input wire logic        clk_in,           // Clock
  input wire logic        rst_n_in,         // Reset
  input wire logic        psel_in,          // APB select
  input wire logic        penable_in,       // APB enable
  input wire logic        pwrite_in,        // APB write
  input wire logic [7:0]  paddr_in,         // APB address
  input wire logic [31:0] pwdata_in,        // APB write data
  input wire logic [31:0] prdata_out,       // APB read data
  input wire logic        pready_out,       // APB ready
  input wire logic        pslverr_out,      // APB error
  input wire logic        sck_out,          // SCK value
  input wire logic        sck_oe_n_out,     // SCK enable
  input wire logic        sdo_oe_n_out,     // SDO enable
  input wire logic        ss_n_in,          // Select
  input wire logic        sleep_in,         // Sleep
  input wire logic        transfer_done_out // Done flag
);
  logic [5:0] ctl_r, ctl_nxt;
  logic [4:0] tgl_r, tgl_nxt;
  logic       sck_q_r;
  wire        wr  = psel_in && penable_in && pready_out && pwrite_in;
  wire        cs4 = ctl_r[5] && ctl_r[3:0] == 4'h4;
  always_comb begin
    ctl_nxt = ctl_r;
    tgl_nxt = tgl_r + {4'h0, !sck_oe_n_out && sck_out != sck_q_r};
    if (wr && paddr_in == 8'h00) ctl_nxt = pwdata_in[5:0];
    // A mode change moves SCK between two sources, so restart the count.
    if (wr && paddr_in == 8'h00) tgl_nxt = 5'h00;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_r   <= 6'h00;
      tgl_r   <= 5'h00;
      sck_q_r <= 1'b0;
    end else begin
      ctl_r   <= ctl_nxt;
      tgl_r   <= tgl_nxt;
      sck_q_r <= sck_out;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_access;
    psel_in && penable_in;
  endsequence
  a_one_wait: assert property (
    s_setup ##1 s_access |-> !pready_out ##1 pready_out)
    else $error("ready not in second access cycle");
  a_err_unmapped: assert property (
    pready_out |-> pslverr_out == (paddr_in > 8'h0C))
    else $error("error response wrong for address");
  a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside ready cycle");
  a_sck_idle: assert property (
    sck_oe_n_out |-> sck_out == ctl_r[4])
    else $error("SCK not at idle level");
  a_sleep_hold: assert property (
    sleep_in [*3] |-> $stable(sck_out))
    else $error("SCK moved in sleep");
  a_sdo_float: assert property (
    (cs4 && ss_n_in) [*2] |-> sdo_oe_n_out)
    else $error("SDO driven while deselected");
  a_sdo_drive: assert property (
    (cs4 && !ss_n_in) [*3] |-> !sdo_oe_n_out)
    else $error("SDO not driven while selected");
  a_sck_count: assert property (tgl_r <= 5'h10)
    else $error("more than eight SCK cycles");
  a_off_float: assert property (
    (!ctl_r[5]) [*2] |-> sck_oe_n_out && sdo_oe_n_out)
    else $error("pins driven while disabled");
  a_done_clear: assert property (
    wr && paddr_in == 8'h04 && pwdata_in[2] |=> !transfer_done_out)
    else $error("done flag not cleared");
endmodule
bind ssp_port ssp_port_monitor ssp_port_monitor_inst (.*);

/* bench/ssp_port_tb.sv */
// Bench for the serial port: APB tasks, host runs, client runs.
// Assumes the peer model and the checker are compiled first.
`timescale 1ns/1ps
module ssp_port_tb;
  logic        clk_in = 0, rst_n_in = 0, psel = 0, pen = 0, pwr = 0;
  logic        tsck = 0, tsdi = 0, ss_n = 1, tick = 0, sleep = 0;
  logic        cli = 0, err_s, pready, pslverr, sck_o, sck_oe_n;
  logic        sdo_o, sdo_oe_n, done, psdi;
  logic [7:0]  paddr = 0, ptx = 0, prx;
  logic [31:0] pwdata = 0, prdata, r;
  logic [3:0]  modes [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA};
  int          errors = 0, total_checks = 0, cyc = 0, edges = 0;
  wire         sck_w = sck_oe_n ? tsck : sck_o;
  wire         sdo_w = sdo_oe_n ? clk_in : sdo_o;
  always #2 clk_in = ~clk_in;
  ssp_port ssp_port_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .sck_in(sck_w), .sck_out(sck_o), .sck_oe_n_out(sck_oe_n),
    .sdi_in(cli ? tsdi : psdi), .sdo_out(sdo_o),
    .sdo_oe_n_out(sdo_oe_n), .ss_n_in(ss_n), .timer_tick_in(tick),
    .sleep_in(sleep), .transfer_done_out(done)
  );
  ssp_peer_model ssp_peer_model_inst (
    .clk_in(clk_in), .sck_in(sck_w), .sdo_in(sdo_w), .sel_n_in(ss_n),
    .tx_in(ptx), .sdi_out(psdi), .rx_out(prx)
  );
  ////////////////////////////////////////
  task automatic close_out;
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel   <= 1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    r = prdata;
    err_s = pslverr;
    psel <= 0;
    pen  <= 0;
  endtask
  // Each bit is held nine clocks: SCK low for three, high for six, above the sync limit.
  task automatic cbyte(input logic [7:0] v, input int n);
    ss_n <= 0;
    for (int k = 7; k > 7 - n; k--) begin
      tsdi <= v[k];
      repeat (3) @(posedge clk_in);
      tsck <= 0;
      repeat (3) @(posedge clk_in);
      tsck <= 1;
      repeat (3) @(posedge clk_in);
    end
    ss_n <= 1;
    repeat (3) @(posedge clk_in);
  endtask
  always @(posedge sck_o) if (!sck_oe_n) edges++;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    tick <= (cyc % 3 == 0);
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1;
    for (int i = 0; i < 5; i++) begin
      apb(0, 8'(i * 4), 32'h0);
      chk("reset_value", r, 32'h0);
      chk("slverr", {31'h0, err_s}, {31'h0, i == 4});
    end
    chk("sck_float", {31'h0, sck_oe_n}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      apb(1, 8'h0C, 32'h2);
      apb(1, 8'h00, 32'h60 | modes[i] | (i == 4 ? 32'h200 : 0) |
                    (i == 2 ? 32'h80 : 0));
      ptx  <= 8'hC3 ^ 8'(i * 17);
      ss_n <= 0;
      edges = 0;
      apb(1, 8'h08, 32'h5A + i);
      apb(1, 8'h08, 32'hFF);
      if (i == 1) begin
        sleep <= 1;
        repeat (40) @(posedge clk_in);
        sleep <= 0;
      end
      if (i == 4) chk("sdo_off", {31'h0, sdo_oe_n}, 32'h1);
      // Busy can drop a cycle before the flags land, so wait for
      // idle together with the done flag.
      do apb(0, 8'h04, 0); while (r[3:2] !== 2'b01);
      chk("stat", r, 32'h7);
      chk("sck_edges", edges, 8);
      apb(0, 8'h08, 0);
      chk("rx_byte", r, {24'h0, ptx});
      if (i != 4) chk("peer_byte", prx, 32'h5A + i);
      apb(1, 8'h04, 32'h6);
      apb(0, 8'h04, 0);
      chk("stat_clear", r, 32'h0);
      ss_n <= 1;
    end
    cli  <= 1;
    tsck <= 1;
    apb(1, 8'h00, 32'h34);
    cbyte(8'hFF, 3);
    cbyte(8'h96, 8);
    chk("done_pin", {31'h0, done}, 32'h1);
    cbyte(8'h5A, 8);
    apb(0, 8'h08, 0);
    chk("kept_byte", r, 32'h96);
    apb(1, 8'h00, 32'h134);
    sleep <= 1;
    cbyte(8'h11, 8);
    cbyte(8'h22, 8);
    sleep <= 0;
    apb(0, 8'h08, 0);
    chk("newest_byte", r, 32'h22);
    chk("sdo_float", {31'h0, sdo_oe_n}, 32'h1);
    close_out();
  end
endmodule

/* rtl/ssp_consts.svh */
// Named constants of the serial port: register map, fields, mode codes.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

`define SSP_A_CTRL    8'h00
`define SSP_A_STAT    8'h04
`define SSP_A_BUF     8'h08
`define SSP_A_RATE    8'h0C

`define SSP_CTRL_RST  10'h000
`define SSP_RATE_RST  8'h00
`define SSP_BYTE_RST  8'h00

`define SSP_F_MODE    3:0
`define SSP_F_CKP     4
`define SSP_F_EN      5
`define SSP_F_CKE     6
`define SSP_F_SMP     7
`define SSP_F_BUFFER_OVERWRITE_ENABLE    8
`define SSP_F_SDOOFF  9

`define SSP_S_WRITE_COLLISION_FLAG    1
`define SSP_S_DONE    2

`define SSP_M_DIV4    4'h0
`define SSP_M_DIV16   4'h1
`define SSP_M_DIV64   4'h2
`define SSP_M_TMR     4'h3
`define SSP_M_CSS     4'h4
`define SSP_M_CFREE   4'h5
`define SSP_M_BRG     4'hA

`define SSP_H_DIV4    10'h002
`define SSP_H_DIV16   10'h008
`define SSP_H_DIV64   10'h020
`define SSP_H_ONE     10'h001

`define SSP_LAST_IN   4'h7
`define SSP_LAST_OUT  4'h8
`define SSP_K_FIRST   5'h01
`define SSP_K_LAST    5'h10
`define SSP_K_LATE    5'h11
`define SSP_K_STEP    5'h01
`define SSP_C_STEP    4'h1

`endif

/* rtl/ssp_pkg.sv */
// Types shared by the serial port design files.
// Assumes the constants header is compiled alongside.
package ssp_pkg;
  typedef enum logic {HS_IDLE, HS_RUN} ssp_hstate_t;
  typedef logic [3:0] ssp_mode_t;
endpackage

/* rtl/ssp_port.sv */
// SPI host/client serial port with an APB register slave.
// Assumes all pin inputs, including SCK in client mode, are synchronous
// to clk_in and that SCK edges are at least two clocks apart.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ssp_consts.svh"
module ssp_port
  import ssp_pkg::*;
(
  input  wire logic        clk_in,            // system clock, 250 MHz
  input  wire logic        rst_n_in,          // async reset, active low
  input  wire logic        psel_in,           // APB select
  input  wire logic        penable_in,        // APB enable
  input  wire logic        pwrite_in,         // APB write
  input  wire logic [7:0]  paddr_in,          // APB byte address
  input  wire logic [31:0] pwdata_in,         // APB write data
  output logic      [31:0] prdata_out,        // APB read data
  output logic             pready_out,        // APB ready
  output logic             pslverr_out,       // APB error, unmapped
  input  wire logic        sck_in,            // SCK pin level
  output logic             sck_out,           // SCK drive value
  output logic             sck_oe_n_out,      // SCK enable, low drives
  input  wire logic        sdi_in,            // serial data in
  output logic             sdo_out,           // serial data out
  output logic             sdo_oe_n_out,      // SDO enable, low drives
  input  wire logic        ss_n_in,           // client select, low
  input  wire logic        timer_tick_in,     // timer output pulse
  input  wire logic        sleep_in,          // device in sleep
  output logic             transfer_done_out  // done flag, wake source
);

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // Returns {sample, output} for one SCK edge.
  function automatic logic [1:0] edge_ev(input logic lead,
                                         input logic cke,
                                         input logic input_sample_phase);
    logic o;
    o = lead ^ cke;
    edge_ev = {(input_sample_phase ? o : ~o), o};
  endfunction

  function automatic logic is_host(input ssp_mode_t m);
    is_host = (m == `SSP_M_DIV4) || (m == `SSP_M_DIV16) ||
              (m == `SSP_M_DIV64) || (m == `SSP_M_TMR) ||
              (m == `SSP_M_BRG);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers and decoded state.

  logic [9:0]  ctrl_r, ctrl_nxt;
  logic [7:0]  rate_r, rate_nxt, buf_r, buf_nxt;
  logic        bf_r, bf_nxt, write_collision_flag_r, write_collision_flag_nxt, done_r, done_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic        sdo_oe_n_r, sdo_oe_n_nxt, sck_oe_n_r, sck_oe_n_nxt;
  logic        sck_q_r;
  ssp_hstate_t hst_r, hst_nxt;
  logic [4:0]  k_r, k_nxt, k_inc;
  logic        sck_r, sck_nxt;

  ssp_mode_t   mode;
  logic        en, clock_idle_polarity, cke, input_sample_phase, host_m, cli_m, ss_ctl, cli_act;
  logic        port_rst, acc, fin, wr_buf, rd_buf, busy, accept;
  logic        start, half_tick, h_lead, c_edge, c_lead;
  logic [1:0]  h_ev, c_ev;
  logic        samp, outev, shf_done, shf_busy, shf_sdo;
  logic [7:0]  shf_byte;
  logic [31:0] rd_word;
  logic        mapped;

  assign mode    = ctrl_r[`SSP_F_MODE];
  assign en      = ctrl_r[`SSP_F_EN];
  assign clock_idle_polarity     = ctrl_r[`SSP_F_CKP];
  assign cke     = ctrl_r[`SSP_F_CKE];
  assign input_sample_phase     = ctrl_r[`SSP_F_SMP];
  assign host_m  = en && is_host(mode);
  assign ss_ctl  = (mode == `SSP_M_CSS);
  assign cli_m   = en && (ss_ctl || (mode == `SSP_M_CFREE));
  assign cli_act = cli_m && (!ss_ctl || !ss_n_in);
  assign port_rst = !en || (cli_m && ss_ctl && ss_n_in);

  ////////////////////////////////////////////////////////////////////////
  // APB decode. Every access takes one wait state, so pready rises in
  // the second access cycle and writes commit on that edge only.

  assign acc    = psel_in && penable_in && !pready_r;
  assign fin    = psel_in && penable_in && pready_r;
  assign wr_buf = fin && pwrite_in && (paddr_in == `SSP_A_BUF);
  assign rd_buf = fin && !pwrite_in && (paddr_in == `SSP_A_BUF);
  assign busy   = (hst_r == HS_RUN) || shf_busy;
  assign accept = wr_buf && en && !busy && !write_collision_flag_r;
  assign start  = accept && host_m;

  always_comb begin
    mapped = 1'b1;
    case (paddr_in)
      `SSP_A_CTRL: rd_word = {22'h000000, ctrl_r};
      `SSP_A_STAT: rd_word = {28'h0000000, busy, done_r, write_collision_flag_r, bf_r};
      `SSP_A_BUF:  rd_word = {24'h000000, buf_r};
      `SSP_A_RATE: rd_word = {24'h000000, rate_r};
      default: begin
        rd_word = 32'h00000000;
        mapped  = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Event decode for host (own SCK) and client (external SCK).

  assign k_inc  = k_r + `SSP_K_STEP;
  assign h_lead = k_inc[0];
  assign h_ev   = edge_ev(h_lead, cke, input_sample_phase);
  assign c_edge = sck_in ^ sck_q_r;
  assign c_lead = c_edge && (sck_in != clock_idle_polarity);
  assign c_ev   = edge_ev(c_lead, cke, input_sample_phase);

  // The host shifts on the SCK it drives itself, so its events come from
  // the same half ticks that toggle sck_r rather than from the pin.
  always_comb begin
    if (host_m) begin
      samp  = (hst_r == HS_RUN) && half_tick && h_ev[1] &&
              !(input_sample_phase && (k_inc == `SSP_K_FIRST));
      outev = (hst_r == HS_RUN) && half_tick && h_ev[0];
    end else begin
      samp  = cli_act && c_edge && c_ev[1];
      outev = cli_act && c_edge && c_ev[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host sequencer: sixteen SCK edges, one extra half period when the
  // last bit is sampled at the end of its output time and CKE is clear.

  always_comb begin
    hst_nxt = hst_r;
    k_nxt   = k_r;
    sck_nxt = sck_r;
    case (hst_r)
      HS_IDLE: begin
        sck_nxt = clock_idle_polarity;
        k_nxt   = '0;
        if (start) begin
          hst_nxt = HS_RUN;
        end
      end
      HS_RUN: begin
        if (half_tick) begin
          k_nxt = k_inc;
          if (k_r < `SSP_K_LAST) begin
            sck_nxt = ~sck_r;
          end
          if (k_inc == ((!cke && input_sample_phase) ? `SSP_K_LATE : `SSP_K_LAST)) begin
            hst_nxt = HS_IDLE;
          end
        end
      end
      default: hst_nxt = HS_IDLE;
    endcase
    // Outside host mode the flop tracks the idle level as it is written,
    // so the pin shows the new polarity in the same cycle as the register.
    if (port_rst || !host_m) begin
      hst_nxt = HS_IDLE;
      k_nxt   = '0;
      sck_nxt = ctrl_nxt[`SSP_F_CKP];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hst_r <= HS_IDLE;
      k_r   <= '0;
      sck_r <= 1'b0;
    end else begin
      hst_r <= hst_nxt;
      k_r   <= k_nxt;
      sck_r <= sck_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers, flags and pin enables. Hardware sets beat software clears.

  always_comb begin
    ctrl_nxt    = ctrl_r;
    rate_nxt    = rate_r;
    buf_nxt     = buf_r;
    bf_nxt      = bf_r;
    write_collision_flag_nxt    = write_collision_flag_r;
    done_nxt    = done_r;
    pready_nxt  = acc;
    pslverr_nxt = acc && !mapped;
    prdata_nxt  = (acc && !pwrite_in) ? rd_word : 32'h00000000;
    if (fin && pwrite_in) begin
      case (paddr_in)
        `SSP_A_CTRL: ctrl_nxt = pwdata_in[9:0];
        `SSP_A_RATE: rate_nxt = pwdata_in[7:0];
        `SSP_A_STAT: begin
          if (pwdata_in[`SSP_S_WRITE_COLLISION_FLAG]) begin
            write_collision_flag_nxt = 1'b0;
          end
          if (pwdata_in[`SSP_S_DONE]) begin
            done_nxt = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (rd_buf) begin
      bf_nxt = 1'b0;
    end
    if (accept) begin
      buf_nxt = pwdata_in[7:0];
    end
    if (wr_buf && en && busy) begin
      write_collision_flag_nxt = 1'b1;
    end
    if (shf_done) begin
      if (!bf_r || ctrl_r[`SSP_F_BUFFER_OVERWRITE_ENABLE]) begin
        buf_nxt = shf_byte;
      end
      bf_nxt   = 1'b1;
      done_nxt = 1'b1;
    end
    if (host_m) begin
      sdo_oe_n_nxt = ctrl_r[`SSP_F_SDOOFF];
      sck_oe_n_nxt = 1'b0;
    end else if (cli_m) begin
      sdo_oe_n_nxt = ss_ctl && ss_n_in;
      sck_oe_n_nxt = 1'b1;
    end else begin
      sdo_oe_n_nxt = 1'b1;
      sck_oe_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r     <= `SSP_CTRL_RST;
      rate_r     <= `SSP_RATE_RST;
      buf_r      <= `SSP_BYTE_RST;
      bf_r       <= 1'b0;
      write_collision_flag_r     <= 1'b0;
      done_r     <= 1'b0;
      prdata_r   <= 32'h00000000;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      sdo_oe_n_r <= 1'b1;
      sck_oe_n_r <= 1'b1;
      sck_q_r    <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      rate_r     <= rate_nxt;
      buf_r      <= buf_nxt;
      bf_r       <= bf_nxt;
      write_collision_flag_r     <= write_collision_flag_nxt;
      done_r     <= done_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      sdo_oe_n_r <= sdo_oe_n_nxt;
      sck_oe_n_r <= sck_oe_n_nxt;
      sck_q_r    <= sck_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Submodules.

  // Sleep only stops the host clock; client shifting keeps going.
  ssp_rate_gen u_rate (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .restart_in    (start),
    .hold_in       (sleep_in || (hst_r != HS_RUN)),
    .mode_in       (mode),
    .divisor_in    (rate_r),
    .timer_tick_in (timer_tick_in),
    .half_tick_out (half_tick)
  );

  ssp_shifter u_shift (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .clr_in    (port_rst),
    .load_in   (accept),
    .data_in   (pwdata_in[7:0]),
    .cke_in    (cke),
    .samp_in   (samp),
    .out_in    (outev),
    .sdi_in    (sdi_in),
    .sdo_out   (shf_sdo),
    .done_out  (shf_done),
    .byte_out  (shf_byte),
    .busy_out  (shf_busy)
  );

  assign prdata_out        = prdata_r;
  assign pready_out        = pready_r;
  assign pslverr_out       = pslverr_r;
  assign sck_out           = sck_r;
  assign sck_oe_n_out      = sck_oe_n_r;
  assign sdo_out           = shf_sdo;
  assign sdo_oe_n_out      = sdo_oe_n_r;
  assign transfer_done_out = done_r;

endmodule

/* rtl/ssp_rate_gen.sv */
// Host bit-rate generator: one pulse per half SCK period.
// Assumes timer_tick_in is a one-cycle pulse in the system clock domain.
`timescale 1ns/1ps
`include "ssp_consts.svh"
module ssp_rate_gen
  import ssp_pkg::*;
(
  input  wire logic       clk_in,        // system clock
  input  wire logic       rst_n_in,      // async reset, active low
  input  wire logic       restart_in,    // start a fresh period
  input  wire logic       hold_in,       // freeze count (sleep, idle)
  input  wire ssp_mode_t  mode_in,       // rate selection
  input  wire logic [7:0] divisor_in,    // rate divisor
  input  wire logic       timer_tick_in, // timer output pulse
  output logic            half_tick_out  // half period elapsed
);

  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;
  logic [9:0] lim;
  logic       tick_r;
  logic       tick_nxt;

  always_comb begin
    case (mode_in)
      `SSP_M_DIV4:  lim = `SSP_H_DIV4;
      `SSP_M_DIV16: lim = `SSP_H_DIV16;
      `SSP_M_DIV64: lim = `SSP_H_DIV64;
      default:      lim = {1'b0, divisor_in, 1'b0} + `SSP_H_DIV4;
    endcase
  end

  // A frozen count resumes mid-period, so a slept transfer picks up exactly.
  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (restart_in) begin
      cnt_nxt = '0;
    end else if (!hold_in) begin
      if (mode_in == `SSP_M_TMR) begin
        tick_nxt = timer_tick_in;
      end else if (cnt_r == lim - `SSP_H_ONE) begin
        cnt_nxt  = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + `SSP_H_ONE;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign half_tick_out = tick_r;

endmodule

/* rtl/ssp_shifter.sv */
// Eight-bit full-duplex shift register with sample and output events.
// Assumes one event pulse per SCK edge, decoded by the caller.
`timescale 1ns/1ps
`include "ssp_consts.svh"
module ssp_shifter
  import ssp_pkg::*;
(
  input  wire logic       clk_in,    // system clock
  input  wire logic       rst_n_in,  // async reset, active low
  input  wire logic       clr_in,    // force bit counters to zero
  input  wire logic       load_in,   // buffer write accepted
  input  wire logic [7:0] data_in,   // byte to transmit
  input  wire logic       cke_in,    // first bit shown at load
  input  wire logic       samp_in,   // sample serial input now
  input  wire logic       out_in,    // move next bit out now
  input  wire logic       sdi_in,    // serial data input
  output logic            sdo_out,   // serial data output
  output logic            done_out,  // byte complete, one cycle
  output logic [7:0]      byte_out,  // received byte
  output logic            busy_out   // byte partly received
);

  logic [7:0] sr_r, sr_nxt, byte_r, byte_nxt;
  logic [3:0] in_r, in_nxt, out_r, out_nxt;
  logic       lat_r, lat_nxt, sdo_r, sdo_nxt, done_nxt, done_r;
  logic       din;
  logic       last;

  assign din  = samp_in ? sdi_in : lat_r;
  assign last = samp_in && (in_r == `SSP_LAST_IN);

  always_comb begin
    sr_nxt   = sr_r;
    byte_nxt = byte_r;
    in_nxt   = in_r;
    out_nxt  = out_r;
    lat_nxt  = lat_r;
    sdo_nxt  = sdo_r;
    done_nxt = 1'b0;
    if (clr_in) begin
      in_nxt  = '0;
      out_nxt = '0;
    end else if (load_in) begin
      sr_nxt  = data_in;
      sdo_nxt = data_in[7];
      out_nxt = {3'b000, cke_in};
      in_nxt  = '0;
    end else begin
      if (samp_in) begin
        lat_nxt = sdi_in;
        in_nxt  = in_r + `SSP_C_STEP;
      end
      if (last) begin
        byte_nxt = {sr_r[6:0], sdi_in};
        sr_nxt   = {sr_r[6:0], sdi_in};
        done_nxt = 1'b1;
        in_nxt   = '0;
        out_nxt  = '0;
      end else if (out_in) begin
        if (out_r == '0) begin
          sdo_nxt = sr_r[7];
          out_nxt = `SSP_C_STEP;
        end else if (out_r < `SSP_LAST_OUT) begin
          sr_nxt  = {sr_r[6:0], din};
          sdo_nxt = sr_r[6];
          out_nxt = out_r + `SSP_C_STEP;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sr_r   <= `SSP_BYTE_RST;
      byte_r <= `SSP_BYTE_RST;
      in_r   <= '0;
      out_r  <= '0;
      lat_r  <= 1'b0;
      sdo_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      sr_r   <= sr_nxt;
      byte_r <= byte_nxt;
      in_r   <= in_nxt;
      out_r  <= out_nxt;
      lat_r  <= lat_nxt;
      sdo_r  <= sdo_nxt;
      done_r <= done_nxt;
    end
  end

  assign sdo_out  = sdo_r;
  assign done_out = done_r;
  assign byte_out = byte_r;
  assign busy_out = (in_r != '0);

endmodule
